// file: hw/drec_fault_slot.sv
// one entry of the recent fault record chain
`timescale 1ns/1ps
`default_nettype none
module drec_fault_slot (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic take,
  input wire logic clr,
  input wire logic valid_in,
  input wire logic [31:0] data_in,
  output logic valid,
  output logic [31:0] data
);
  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } drec_slot_t;
  drec_slot_t st_reg;
  drec_slot_t st_next;

  // a shift wins over a clear so a new fault is not lost
  always_comb begin
    st_next = st_reg;
    if (take) begin
      st_next.valid = valid_in;
      st_next.data = data_in;
    end else if (clr) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign valid = st_reg.valid;
  assign data = st_reg.data;
endmodule : drec_fault_slot
`default_nettype wire

// file: hw/drec_recorder.sv
// disturbance recorder: capture buffer, triggering, upload and fault history
`timescale 1ns/1ps
`default_nettype none
`include "drec_regs.svh"
module drec_recorder #(
  parameter int CLK_HZ = `DREC_CLK_HZ
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire drec_pkg::drec_bus_t bus,
  output logic [31:0] rdata,
  input wire drec_pkg::drec_analog_t samples,
  input wire drec_pkg::drec_analog_t rms_values,
  input wire logic [15:0] internal_sig,
  input wire logic [7:0] input_sig,
  input wire logic [31:0] timestamp,
  input wire drec_pkg::drec_fault_in_t fault_in,
  input wire logic master_reset,
  input wire logic power_restart,
  output logic ready_ind,
  output logic trigger_event_code,
  output logic clear_event_code
);
  import drec_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    drec_state_t state;
    logic [2:0] sample_rate_select;
    logic [15:0] internal_channel_select;
    logic [7:0] input_channel_select;
    logic [11:0] post_trigger_length;
    logic [1:0] recorder_event_mask;
    logic [15:0] internal_trigger_select;
    logic [15:0] internal_trigger_edge;
    logic [7:0] input_trigger_select;
    logic [7:0] input_trigger_edge;
    logic nonvolatile;
    logic [23:0] prev_sig;
    logic prev_start;
    logic [31:0] div_cnt;
    logic [11:0] wr_ptr;
    logic [11:0] fill;
    logic [11:0] post_cnt;
    logic [31:0] trig_stamp;
    logic [11:0] up_ptr;
    logic [1:0] up_word;
    logic [15:0] trip_count;
    logic [15:0] shot_count;
    logic [15:0] start_count;
    logic [31:0] rdata;
    logic ready_ind;
    logic trig_ev;
    logic clr_ev;
  } drec_core_t;

  drec_core_t st_reg;
  drec_core_t st_next;
  drec_sample_t mem [0:4095];
  drec_sample_t cur_sample;
  drec_sample_t up_sample;
  logic mem_we;
  logic [31:0] div_lim;
  logic [4:0] fault_valid;
  logic [4:0][31:0] fault_data;
  logic fault_store;

  // ---------------------------------------------------------------
  // channel packing
  // ---------------------------------------------------------------
  // first eight selected bits, internal signals in the low positions
  function automatic logic [7:0] drec_pack(input logic [23:0] sig, input logic [23:0] sel);
    logic [7:0] out;
    logic [3:0] n;
    out = 8'h00;
    n = 4'h0;
    for (int i = 0; i < 24; i++) begin
      if (sel[i] && n < 4'h8) begin
        out[n[2:0]] = sig[i];
        n = n + 4'h1;
      end
    end
    return out;
  endfunction : drec_pack

  // sample word; RMS curve replaces momentary values for rate code DREC_RATE_RMS only, not for the other 1x code
  always_comb begin
    cur_sample.analog = (st_reg.sample_rate_select[1:0] == `DREC_RATE_RMS) ?
                        rms_values : samples;
    cur_sample.digital = drec_pack({input_sig, internal_sig},
      {st_reg.input_channel_select, st_reg.internal_channel_select});
  end

  // sample pacing from the nominal frequency and multiplier
  always_comb begin
    logic [31:0] nom;
    logic [31:0] mult;
    mult = `DREC_MULT_X1;
    nom = st_reg.sample_rate_select[2] ? `DREC_NOM_60 : `DREC_NOM_50;
    case (st_reg.sample_rate_select[1:0])
      `DREC_RATE_X16: mult = `DREC_MULT_X16;
      `DREC_RATE_X8: mult = `DREC_MULT_X8;
      default: mult = `DREC_MULT_X1;
    endcase
    div_lim = 32'(CLK_HZ) / (nom * mult);
  end

  assign up_sample = mem[st_reg.up_ptr];
  assign fault_store = (st_reg.prev_start & ~fault_in.start_alarm_any) | fault_in.stage_trip;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic tick;
    logic [23:0] sig;
    logic [23:0] tsel;
    logic [23:0] tedge;
    logic sig_hit;
    logic manual;
    logic erase;
    logic untrig;
    // sample pacing; the pacer keeps running so the rate stays even
    tick = (st_reg.div_cnt + 32'h1 >= div_lim);
    sig = {input_sig, internal_sig};
    tsel = {st_reg.input_trigger_select, st_reg.internal_trigger_select};
    tedge = {st_reg.input_trigger_edge, st_reg.internal_trigger_edge};
    untrig = (st_reg.state == DREC_ARMED);
    // rising when edge bit low, falling when high
    sig_hit = |(tsel & ((~tedge & sig & ~st_reg.prev_sig) |
                        (tedge & ~sig & st_reg.prev_sig)));
    manual = bus.wr && (bus.addr == `DREC_A_MANUAL);
    erase = 1'b0;
    st_next = st_reg;
    st_next.trig_ev = 1'b0;
    st_next.clr_ev = 1'b0;
    mem_we = 1'b0;
    st_next.prev_sig = sig;
    st_next.prev_start = fault_in.start_alarm_any;

    st_next.div_cnt = tick ? 32'h0 : st_reg.div_cnt + 32'h1;

    // register writes
    if (bus.wr) begin
      if (bus.addr == `DREC_A_RATE) begin
        if (untrig) st_next.sample_rate_select = bus.wdata[2:0];
      end else if (bus.addr == `DREC_A_INT_CH) begin
        if (untrig) st_next.internal_channel_select = bus.wdata[15:0];
      end else if (bus.addr == `DREC_A_IN_CH) begin
        if (untrig) st_next.input_channel_select = bus.wdata[7:0];
      end else if (bus.addr == `DREC_A_POST) begin
        // longer than the whole buffer is clamped to it
        st_next.post_trigger_length = (bus.wdata[11:0] > `DREC_DEPTH || |bus.wdata[31:12]) ?
                                      `DREC_DEPTH : bus.wdata[11:0];
      end else if (bus.addr == `DREC_A_STATUS) begin
        if (bus.wdata == `DREC_CMD_TWO) begin
          // oldest sample first once the ring has wrapped
          st_next.up_ptr = (st_reg.fill == `DREC_DEPTH) ? st_reg.wr_ptr : 12'h000;
          st_next.up_word = 2'h0;
        end
      end else if (bus.addr == `DREC_A_CLEAR) begin
        if (bus.wdata == `DREC_CMD_ONE) erase = 1'b1;
      end else if (bus.addr == `DREC_A_EVMASK) begin
        st_next.recorder_event_mask = bus.wdata[1:0];
      end else if (bus.addr == `DREC_A_INT_TSEL) begin
        st_next.internal_trigger_select = bus.wdata[15:0];
      end else if (bus.addr == `DREC_A_INT_TEDGE) begin
        st_next.internal_trigger_edge = bus.wdata[15:0];
      end else if (bus.addr == `DREC_A_IN_TSEL) begin
        st_next.input_trigger_select = bus.wdata[7:0];
      end else if (bus.addr == `DREC_A_IN_TEDGE) begin
        st_next.input_trigger_edge = bus.wdata[7:0];
      end else if (bus.addr == `DREC_A_CNT) begin
        if (bus.wdata == `DREC_CMD_ONE) st_next.trip_count = 16'h0000;
        if (bus.wdata == `DREC_CMD_TWO) st_next.shot_count = 16'h0000;
      end else if (bus.addr == `DREC_A_NVCFG) begin
        st_next.nonvolatile = bus.wdata[0];
      end
    end

    // counters count after a clear so a same-cycle event survives
    if (master_reset) st_next.start_count = 16'h0000;
    if (fault_in.stage_trip) st_next.trip_count = st_next.trip_count + 16'h0001;
    if (fault_in.ar_shot) st_next.shot_count = st_next.shot_count + 16'h0001;
    if (fault_in.start_alarm_any && !st_reg.prev_start) begin
      st_next.start_count = st_next.start_count + 16'h0001;
    end

    // recorder state machine
    case (st_reg.state)
      DREC_ARMED: begin
        if (sig_hit || manual) begin
          st_next.state = DREC_POST;
          st_next.post_cnt = 12'h000;
          st_next.trig_stamp = timestamp;
          st_next.trig_ev = st_reg.recorder_event_mask[0];
          if (st_reg.post_trigger_length == 12'h000) st_next.state = DREC_READY;
        end
      end
      DREC_POST: begin
        // further trigger conditions are simply not looked at here
        if (tick) begin
          st_next.post_cnt = st_reg.post_cnt + 12'h001;
          if (st_reg.post_cnt + 12'h001 >= st_reg.post_trigger_length) begin
            st_next.state = DREC_READY;
          end
        end
      end
      DREC_READY: begin
        st_next.state = DREC_READY;
      end
      default: begin
        st_next.state = DREC_ARMED;
      end
    endcase

    // capture into the ring; a full post length overwrites all history
    if (tick && st_reg.state != DREC_READY) begin
      mem_we = 1'b1;
      st_next.wr_ptr = (st_reg.wr_ptr == `DREC_LAST) ? 12'h000 : st_reg.wr_ptr + 12'h001;
      // depth is the same 4000 samples at every rate
      if (st_reg.fill != `DREC_DEPTH) st_next.fill = st_reg.fill + 12'h001;
    end

    // power restart keeps a finished recording only if non-volatile
    if (power_restart && !(st_reg.nonvolatile && st_reg.state == DREC_READY)) begin
      erase = 1'b1;
    end
    if (master_reset) erase = 1'b1;
    if (erase) begin
      st_next.state = DREC_ARMED;
      st_next.wr_ptr = 12'h000;
      st_next.fill = 12'h000;
      st_next.post_cnt = 12'h000;
      st_next.up_ptr = 12'h000;
      st_next.up_word = 2'h0;
      st_next.trig_ev = 1'b0;
      st_next.clr_ev = st_reg.recorder_event_mask[1];
      mem_we = 1'b0;
    end
    st_next.ready_ind = (st_next.state == DREC_READY);

    // read data, valid only in the cycle after the strobe
    st_next.rdata = 32'h0000_0000;
    if (bus.rd) begin
      if (bus.addr == `DREC_A_RATE) begin
        st_next.rdata = {29'h0, st_reg.sample_rate_select};
      end else if (bus.addr == `DREC_A_INT_CH) begin
        st_next.rdata = {16'h0, st_reg.internal_channel_select};
      end else if (bus.addr == `DREC_A_IN_CH) begin
        st_next.rdata = {24'h0, st_reg.input_channel_select};
      end else if (bus.addr == `DREC_A_POST) begin
        st_next.rdata = {20'h0, st_reg.post_trigger_length};
      end else if (bus.addr == `DREC_A_STATUS) begin
        st_next.rdata = {31'h0, st_reg.state == DREC_READY};
      end else if (bus.addr == `DREC_A_EVMASK) begin
        st_next.rdata = {30'h0, st_reg.recorder_event_mask};
      end else if (bus.addr == `DREC_A_INT_TSEL) begin
        st_next.rdata = {16'h0, st_reg.internal_trigger_select};
      end else if (bus.addr == `DREC_A_INT_TEDGE) begin
        st_next.rdata = {16'h0, st_reg.internal_trigger_edge};
      end else if (bus.addr == `DREC_A_IN_TSEL) begin
        st_next.rdata = {24'h0, st_reg.input_trigger_select};
      end else if (bus.addr == `DREC_A_IN_TEDGE) begin
        st_next.rdata = {24'h0, st_reg.input_trigger_edge};
      end else if (bus.addr == `DREC_A_CNT) begin
        st_next.rdata = {st_reg.shot_count, st_reg.trip_count};
      end else if (bus.addr == `DREC_A_UPLOAD) begin
        // time stamp first, then three words per sample
        if (st_reg.state == DREC_READY) begin
          case (st_reg.up_word)
            2'h0: st_next.rdata = st_reg.trig_stamp;
            2'h1: st_next.rdata = {up_sample.analog.ch[1], up_sample.analog.ch[0]};
            2'h2: st_next.rdata = {up_sample.analog.ch[3], up_sample.analog.ch[2]};
            default: st_next.rdata = {24'h0, up_sample.digital};
          endcase
          if (st_reg.up_word == 2'h3) begin
            st_next.up_word = 2'h1;
            st_next.up_ptr = (st_reg.up_ptr == `DREC_LAST) ? 12'h000 : st_reg.up_ptr + 12'h001;
          end else begin
            st_next.up_word = st_reg.up_word + 2'h1;
          end
        end
      end else if (bus.addr == `DREC_A_NVCFG) begin
        st_next.rdata = {17'h0, st_reg.fill, st_reg.state, st_reg.nonvolatile};
      end else if (bus.addr == `DREC_A_STARTS) begin
        st_next.rdata = {16'h0, st_reg.start_count};
      end else if (bus.addr >= `DREC_A_FAULT0 && bus.addr <= `DREC_A_FAULT4) begin
        st_next.rdata = fault_data[3'(bus.addr - `DREC_A_FAULT0)];
      end else begin
        st_next.rdata = 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.state <= DREC_ARMED;
      st_reg.sample_rate_select <= `DREC_RATE_RST;
      st_reg.recorder_event_mask <= `DREC_EVMASK_RST;
      st_reg.post_trigger_length <= `DREC_POST_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // sample memory is not reset; the fill count says what is valid
  always_ff @(posedge clk) begin
    if (ce && mem_we) begin
      mem[st_reg.wr_ptr] <= cur_sample;
    end
  end

  // ---------------------------------------------------------------
  // fault history, slot 0 is the newest
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 5; i++) begin : g_fault
    logic vin;
    logic [31:0] din;
    if (i == 0) begin : g_head
      assign vin = 1'b1;
      assign din = fault_in.fault_data;
    end else begin : g_tail
      // master reset in the same cycle leaves only the new entry valid; older data still shifts down and reads back
      assign vin = fault_valid[i-1] & ~master_reset;
      assign din = fault_data[i-1];
    end
    drec_fault_slot u_slot (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .take(fault_store),
      .clr(master_reset),
      .valid_in(vin),
      .data_in(din),
      .valid(fault_valid[i]),
      .data(fault_data[i])
    );
  end

  assign rdata = st_reg.rdata;
  assign ready_ind = st_reg.ready_ind;
  assign trigger_event_code = st_reg.trig_ev;
  assign clear_event_code = st_reg.clr_ev;
endmodule : drec_recorder
`default_nettype wire

// file: pkg/drec_pkg.sv
// types shared by the disturbance recorder modules
package drec_pkg;
  typedef enum logic [1:0] {
    DREC_ARMED = 2'b00,
    DREC_POST = 2'b01,
    DREC_READY = 2'b11
  } drec_state_t;
  typedef struct packed {
    logic [4:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } drec_bus_t;
  typedef struct packed {
    logic [3:0][15:0] ch;
  } drec_analog_t;
  typedef struct packed {
    drec_analog_t analog;
    logic [7:0] digital;
  } drec_sample_t;
  typedef struct packed {
    logic stage_trip;
    logic ar_shot;
    logic start_alarm_any;
    logic [31:0] fault_data;
  } drec_fault_in_t;
endpackage : drec_pkg

// file: pkg/drec_regs.svh
// register offsets, field codes and timing figures of the disturbance recorder
`ifndef DREC_REGS_SVH
`define DREC_REGS_SVH
`define DREC_A_RATE 5'h00
`define DREC_A_INT_CH 5'h01
`define DREC_A_IN_CH 5'h02
`define DREC_A_POST 5'h03
`define DREC_A_STATUS 5'h04
`define DREC_A_MANUAL 5'h05
`define DREC_A_CLEAR 5'h06
`define DREC_A_EVMASK 5'h07
`define DREC_A_INT_TSEL 5'h08
`define DREC_A_INT_TEDGE 5'h09
`define DREC_A_IN_TSEL 5'h0a
`define DREC_A_IN_TEDGE 5'h0b
`define DREC_A_CNT 5'h0c
`define DREC_A_UPLOAD 5'h0d
`define DREC_A_NVCFG 5'h0e
`define DREC_A_STARTS 5'h0f
`define DREC_A_FAULT0 5'h10
`define DREC_A_FAULT4 5'h14
`define DREC_CMD_ONE 32'h0000_0001
`define DREC_CMD_TWO 32'h0000_0002
`define DREC_RATE_X16 2'h0
`define DREC_RATE_X8 2'h1
`define DREC_RATE_RMS 2'h2
`define DREC_NOM_50 32'h0000_0032
`define DREC_NOM_60 32'h0000_003c
`define DREC_MULT_X16 32'h0000_0010
`define DREC_MULT_X8 32'h0000_0008
`define DREC_MULT_X1 32'h0000_0001
`define DREC_CYC_X16 32'h0000_00fa
`define DREC_CYC_X8 32'h0000_01f4
`define DREC_CYC_RMS 32'h0000_0fa0
`define DREC_DEPTH 12'hfa0
`define DREC_LAST 12'hf9f
`define DREC_RATE_RST 3'h0
`define DREC_EVMASK_RST 2'h3
`define DREC_POST_RST 12'h7d0
`define DREC_CLK_HZ 200000000
`endif

// file: verification/drec_host_model.sv
// host side model issuing parameter writes and reads
`timescale 1ns/1ps
`default_nettype none
module drec_host_model (
  input wire logic clk,
  input wire logic [31:0] rdata,
  output var drec_pkg::drec_bus_t bus
);
  import drec_pkg::*;
  initial bus = '0;
  // one write; released lines show inverted values so stale data never looks valid
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : wr
  // one read; data taken in the single cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b0};
    #1 d = rdata;
  endtask : rd
endmodule : drec_host_model
`default_nettype wire

// file: verification/drec_recorder_asserts.sv
// port checker of the disturbance recorder
`timescale 1ns/1ps
`default_nettype none
`include "drec_regs.svh"
module drec_recorder_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire drec_pkg::drec_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic master_reset,
  input wire logic power_restart,
  input wire logic ready_ind,
  input wire logic trigger_event_code,
  input wire logic clear_event_code
);
  import drec_pkg::*;
  logic [1:0] mask_reg;
  logic wr_clr;
  logic erase_any;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  // shadow mask, needed to know whether a clear event may show
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_reg <= `DREC_EVMASK_RST;
    end else if (ce && bus.wr && bus.addr == `DREC_A_EVMASK) begin
      mask_reg <= bus.wdata[1:0];
    end
  end
  // every way the recording may be erased
  assign wr_clr = ce && bus.wr && bus.addr == `DREC_A_CLEAR && bus.wdata == `DREC_CMD_ONE;
  assign erase_any = wr_clr || (ce && (master_reset || power_restart));
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_status_rd;
    ce && bus.rd && bus.addr == `DREC_A_STATUS |=> rdata == {31'h0, $past(ready_ind)};
  endproperty
  a_status_rd: assert property (p_status_rd)
    else $error("status read value wrong");
  property p_rdata_idle;
    ce && !bus.rd |=> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero without read");
  property p_no_retrig;
    ready_ind && ce |=> !trigger_event_code;
  endproperty
  a_no_retrig: assert property (p_no_retrig)
    else $error("trigger while recording ready");
  property p_trig_once;
    trigger_event_code && ce |=> !trigger_event_code;
  endproperty
  a_trig_once: assert property (p_trig_once)
    else $error("trigger event longer than one cycle");
  property p_clear_evt;
    wr_clr |=> !ready_ind && clear_event_code == mask_reg[1];
  endproperty
  a_clear_evt: assert property (p_clear_evt)
    else $error("clear did not re-arm or event wrong");
  property p_mreset;
    ce && master_reset |=> !ready_ind;
  endproperty
  a_mreset: assert property (p_mreset)
    else $error("master reset kept the recording");
  property p_ready_hold;
    ready_ind && ce && !erase_any |=> $stable(ready_ind);
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped without erase");
  property p_clr_cause;
    clear_event_code && $past(ce) |-> $past(erase_any);
  endproperty
  a_clr_cause: assert property (p_clr_cause)
    else $error("clear event without erase");
endmodule : drec_recorder_asserts
bind drec_recorder drec_recorder_asserts i_chk (
  .clk(clk), .srst(srst), .ce(ce), .bus(bus), .rdata(rdata),
  .master_reset(master_reset), .power_restart(power_restart), .ready_ind(ready_ind),
  .trigger_event_code(trigger_event_code), .clear_event_code(clear_event_code)
);
`default_nettype wire

// file: verification/drec_recorder_tb.sv
// self-checking bench of the disturbance recorder
`timescale 1ns/1ps
`default_nettype none
`include "drec_regs.svh"
module drec_recorder_tb;
  import drec_pkg::*;
  logic clk, srst, ce, master_reset, power_restart, ready_ind, trig_ev, clr_ev;
  logic [31:0] rdata, timestamp, rd_val, ts_exp, cnt_val, w1;
  logic [31:0] seed = 32'd62;
  logic [15:0] internal_sig;
  logic [7:0] input_sig;
  logic [3:0] k;
  logic [31:0] fdat [6];
  drec_bus_t bus;
  drec_analog_t samples, rms_values;
  drec_fault_in_t fault_in;
  int failures, cmp_count, cycles;
  // ----------------------------------------
  // design, host and clock
  // ----------------------------------------
  // short pacer keeps post-trigger phases within 1280 cycles, the length of one sample at the rms rate
  drec_recorder #(.CLK_HZ(64000)) i_dut (.clk(clk), .srst(srst), .ce(ce), .bus(bus),
    .rdata(rdata), .samples(samples), .rms_values(rms_values), .internal_sig(internal_sig),
    .input_sig(input_sig), .timestamp(timestamp), .fault_in(fault_in),
    .master_reset(master_reset), .power_restart(power_restart), .ready_ind(ready_ind),
    .trigger_event_code(trig_ev), .clear_event_code(clr_ev));
  drec_host_model i_host (.clk(clk), .rdata(rdata), .bus(bus));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // newest fault first, oldest of six dropped
  function automatic logic [31:0] newest(input int i);
    return fdat[5 - i];
  endfunction : newest
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // a trigger pulse may lag the cause by a sync stage, so look over four cycles
  task automatic watch_trig(input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (4) begin
      #1 seen = seen | trig_ev;
      @(posedge clk);
    end
    check({31'h0, seen}, {31'h0, exp});
  endtask : watch_trig
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready_ind !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    check({31'h0, ready_ind}, 32'h1);
  endtask : wait_ready
  task automatic clear(input logic ev);
    i_host.wr(`DREC_A_CLEAR, `DREC_CMD_ONE);
    #1 check({31'h0, clr_ev}, {31'h0, ev});
    i_host.rd(`DREC_A_STATUS, rd_val);
    check(rd_val, 32'h0);
  endtask : clear
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test
  // random stream into the inputs, plus the hang limit
  always @(posedge clk) begin
    seed <= xs(seed);
    samples <= {seed, ~seed};
    // rms words repeat, momentary words invert: tells the two apart on upload
    rms_values <= {seed, seed};
    input_sig <= seed[7:0];
    timestamp <= seed;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    cmp_count = 0;
    srst = 1'b1;
    ce = 1'b1;
    master_reset = 1'b0;
    power_restart = 1'b0;
    internal_sig = '0;
    fault_in = '0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    i_host.rd(`DREC_A_STATUS, rd_val);
    check(rd_val, 32'h0);
    i_host.wr(`DREC_A_POST, 32'h3);
    i_host.wr(`DREC_A_MANUAL, 32'h0);
    ts_exp = timestamp;
    watch_trig(1'b1);
    i_host.rd(`DREC_A_STATUS, rd_val);
    check(rd_val, 32'h0);
    i_host.wr(`DREC_A_RATE, 32'h1);
    i_host.rd(`DREC_A_RATE, rd_val);
    check(rd_val, 32'h0);
    wait_ready();
    i_host.rd(`DREC_A_STATUS, rd_val);
    check(rd_val, 32'h1);
    i_host.wr(`DREC_A_MANUAL, 32'h0);
    watch_trig(1'b0);
    i_host.wr(`DREC_A_STATUS, `DREC_CMD_TWO);
    i_host.rd(`DREC_A_UPLOAD, rd_val);
    check(rd_val, ts_exp);
    // first sample at the 16x rate holds momentary values, no channel picked
    i_host.rd(`DREC_A_UPLOAD, w1);
    i_host.rd(`DREC_A_UPLOAD, rd_val);
    check(w1, ~rd_val);
    i_host.rd(`DREC_A_UPLOAD, rd_val);
    check(rd_val, 32'h0);
    clear(1'b1);
    i_host.wr(`DREC_A_RATE, 32'h1);
    i_host.rd(`DREC_A_RATE, rd_val);
    check(rd_val, 32'h1);
    // rising then falling edge choice on a random internal signal
    for (int e = 0; e < 2; e++) begin
      k = seed[3:0];
      i_host.wr(`DREC_A_INT_TSEL, 32'h1 << k);
      i_host.wr(`DREC_A_INT_TEDGE, 32'(e) << k);
      internal_sig[k] <= 1'b1;
      watch_trig(e == 0);
      internal_sig[k] <= 1'b0;
      watch_trig(e == 1);
      wait_ready();
      clear(1'b1);
    end
    // both events masked
    i_host.wr(`DREC_A_EVMASK, 32'h0);
    i_host.wr(`DREC_A_MANUAL, 32'h0);
    watch_trig(1'b0);
    wait_ready();
    clear(1'b0);
    i_host.wr(`DREC_A_EVMASK, 32'h3);
    // six faults into a five-deep history
    for (int i = 0; i < 6; i++) begin
      fdat[i] = seed;
      fault_in.fault_data <= seed;
      fault_in.stage_trip <= 1'b1;
      @(posedge clk);
      fault_in.stage_trip <= 1'b0;
      @(posedge clk);
    end
    for (int i = 0; i < 5; i++) begin
      i_host.rd(5'(`DREC_A_FAULT0 + i), rd_val);
      check(rd_val, newest(i));
    end
    i_host.rd(`DREC_A_CNT, cnt_val);
    i_host.wr(`DREC_A_MANUAL, 32'h0);
    wait_ready();
    @(posedge clk);
    master_reset <= 1'b1;
    @(posedge clk);
    master_reset <= 1'b0;
    i_host.rd(`DREC_A_STATUS, rd_val);
    check(rd_val, 32'h0);
    i_host.rd(`DREC_A_FAULT0, rd_val);
    check(rd_val, 32'h0);
    i_host.rd(`DREC_A_CNT, rd_val);
    check(rd_val, cnt_val);
    check(cnt_val, 32'h0000_0006);
    i_host.wr(`DREC_A_CNT, `DREC_CMD_ONE);
    i_host.rd(`DREC_A_CNT, rd_val);
    check(rd_val, 32'h0);
    @(posedge clk);
    fault_in.ar_shot <= 1'b1;
    @(posedge clk);
    fault_in.ar_shot <= 1'b0;
    i_host.rd(`DREC_A_CNT, rd_val);
    check(rd_val, 32'h0001_0000);
    i_host.wr(`DREC_A_CNT, `DREC_CMD_TWO);
    i_host.rd(`DREC_A_CNT, rd_val);
    check(rd_val, 32'h0);
    // power return keeps a non-volatile ready recording, drops a volatile one
    i_host.wr(`DREC_A_NVCFG, 32'h1);
    i_host.wr(`DREC_A_MANUAL, 32'h0);
    wait_ready();
    @(posedge clk);
    power_restart <= 1'b1;
    @(posedge clk);
    power_restart <= 1'b0;
    i_host.rd(`DREC_A_STATUS, rd_val);
    check(rd_val, 32'h1);
    i_host.wr(`DREC_A_NVCFG, 32'h0);
    @(posedge clk);
    power_restart <= 1'b1;
    @(posedge clk);
    power_restart <= 1'b0;
    i_host.rd(`DREC_A_STATUS, rd_val);
    check(rd_val, 32'h0);
    // rate equal to nominal stores the rms words
    i_host.wr(`DREC_A_POST, 32'h1);
    i_host.wr(`DREC_A_RATE, 32'h2);
    clear(1'b1);
    i_host.wr(`DREC_A_MANUAL, 32'h0);
    wait_ready();
    i_host.wr(`DREC_A_STATUS, `DREC_CMD_TWO);
    i_host.rd(`DREC_A_UPLOAD, w1);
    i_host.rd(`DREC_A_UPLOAD, w1);
    i_host.rd(`DREC_A_UPLOAD, rd_val);
    check(w1, rd_val);
    finish_test();
  end
endmodule : drec_recorder_tb
`default_nettype wire
